/* File: design/lsr_map.svh */
// Behaviour
// RULE1: a cycle starts only on the rising edge of the cycle strobe
// RULE2: strobe low after the access starts the internal preset for the next cycle
// RULE3: address and chip select are latched at cycle start and held all cycle
// RULE4: read data sits in an output register until the next cycle begins; the code clears it when strobe falls with drivers disabled
// RULE5: write select high means read; low while strobe high means write
// RULE6: write and read data share four two-way data pins
// RULE7: memory status shows data valid and preset complete
// RULE8: controller may time the strobe from the memory status output
// RULE9: strobe may stop in either level indefinitely without losing state
// RULE10: array is 1024 words of 4 bits; one word per cycle
// RULE11: controller keeps strobe low at least the preset interval
// RULE12: write only when selected, strobe high and write select low
// RULE13: unselected cycle keeps drivers off and writes nothing
// RULE14: drivers on only with output enable high and drive-off request low
// RULE15: controller holds strobe low after power-on for an initial preset
// RULE16: controller releases data lines before device drivers may turn on
// RULE17: read-modify-write lowers write select only after read data is valid
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH
`define LSR_ADDR_W 10
`define LSR_DATA_W 4
`define LSR_WORDS 1024
`define LSR_ACCESS_NS 200
`define LSR_PRESET_NS 100
`define LSR_CLK_NS 40
`define LSR_ACCESS_CYC ((`LSR_ACCESS_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_PRESET_CYC ((`LSR_PRESET_NS + `LSR_CLK_NS - 1) / `LSR_CLK_NS)
`define LSR_CNT_W 4
`endif

/* File: design/lsr_pkg.sv */
`include "lsr_map.svh"
package lsr_pkg;
	typedef enum logic [1:0] {
		LSR_PRESET = 2'b00,
		LSR_IDLE   = 2'b01,
		LSR_ACCESS = 2'b11,
		LSR_VALID  = 2'b10
	} lsr_state_e;
	typedef logic [`LSR_CNT_W-1:0] lsr_cnt_t;
endpackage : lsr_pkg

/* File: design/lsr_mem_if.sv */
`timescale 1ns/1ps
`include "lsr_map.svh"
interface lsr_mem_if #(parameter int AW = `LSR_ADDR_W, parameter int DW = `LSR_DATA_W);
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface : lsr_mem_if

/* File: design/lsr_array.sv */
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_array #(
	parameter int WORDS = `LSR_WORDS
) (
	input  wire logic i_clk,
	lsr_mem_if.mem    mem
);
	logic [$bits(mem.wdata)-1:0] store [WORDS];

	// no reset: contents survive any strobe stall
	always_ff @(posedge i_clk) begin // RULE9
		if (mem.we) begin // RULE10
			store[mem.addr] <= mem.wdata;
		end
		mem.rdata <= store[mem.addr];
	end
endmodule : lsr_array

/* File: design/lsr_cycle_port.sv */
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_cycle_port import lsr_pkg::*; #(
	parameter int AW = `LSR_ADDR_W,
	parameter int DW = `LSR_DATA_W
) (
	// clock and reset
	input  wire logic          i_mclk,
	input  wire logic          i_nrst,
	// cycle control
	input  wire logic          i_cycle_strobe,
	input  wire logic          i_chip_select,
	input  wire logic          i_write_n,
	input  wire logic [AW-1:0] i_addr,
	// output buffer control
	input  wire logic          i_output_enable,
	input  wire logic          i_drive_off_request,
	// shared data pins
	input  wire logic [DW-1:0] i_data,
	output logic      [DW-1:0] o_data,
	output logic               o_data_oe,
	// status
	output logic               o_memory_status
);
	logic       rst_meta_q;
	logic       rst_sync_q;
	logic       strobe_q;
	lsr_state_e state_q;
	lsr_cnt_t   cnt_q;
	logic [AW-1:0] addr_q;
	logic       sel_q;
	logic       wrote_q;
	logic       rd_take_q;
	logic       clr_q;
	logic [DW-1:0] dout_q;
	logic       rise;
	logic       drv_ok;

	lsr_mem_if #(.AW(AW), .DW(DW)) mif ();

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rise   = i_cycle_strobe && !strobe_q; // RULE1
	assign drv_ok = i_output_enable && !i_drive_off_request; // RULE14

	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= i_cycle_strobe;
		end
	end

	// address and select held for the whole cycle
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			addr_q <= '0;
			sel_q  <= 1'b0;
		end else if (rise && state_q == LSR_IDLE) begin // RULE3
			addr_q <= i_addr;
			sel_q  <= i_chip_select;
		end
	end

	// strobe high before preset ends restarts the preset count, so the preset is never cut short
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= LSR_PRESET;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				LSR_PRESET: begin // RULE2
					if (i_cycle_strobe) begin
						cnt_q <= '0;
					end else if (cnt_q == lsr_cnt_t'(`LSR_PRESET_CYC - 1)) begin
						state_q <= LSR_IDLE;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + lsr_cnt_t'(1);
					end
				end
				LSR_IDLE: begin
					if (rise) begin // RULE1
						state_q <= LSR_ACCESS;
						cnt_q   <= '0;
					end
				end
				LSR_ACCESS: begin
					if (!i_cycle_strobe) begin
						state_q <= LSR_PRESET;
						cnt_q   <= '0;
					end else if (cnt_q == lsr_cnt_t'(`LSR_ACCESS_CYC - 1)) begin
						state_q <= LSR_VALID;
					end else begin
						cnt_q <= cnt_q + lsr_cnt_t'(1);
					end
				end
				LSR_VALID: begin
					if (!i_cycle_strobe) begin // RULE9
						state_q <= LSR_PRESET;
						cnt_q   <= '0;
					end
				end
				default: begin
					state_q <= LSR_PRESET;
					cnt_q   <= '0;
				end
			endcase
		end
	end

	// write window: selected, strobe high, write select low
	assign mif.we    = sel_q && i_cycle_strobe && !i_write_n && // RULE12 RULE13 RULE5
	                   (state_q == LSR_ACCESS || state_q == LSR_VALID);
	assign mif.addr  = addr_q;
	assign mif.wdata = i_data; // RULE6

	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wrote_q   <= 1'b0;
			rd_take_q <= 1'b0;
		end else begin
			wrote_q   <= mif.we;
			rd_take_q <= (state_q == LSR_ACCESS) && (cnt_q == lsr_cnt_t'(`LSR_ACCESS_CYC - 1));
		end
	end

	// output register: loaded at access end, refreshed after a write, cleared when
	// strobe falls with drivers disabled
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			dout_q <= '0;
			clr_q  <= 1'b0;
		end else begin
			clr_q <= (state_q == LSR_VALID) && !i_cycle_strobe && !drv_ok;
			if (clr_q) begin
				dout_q <= '0;
			end else if (rd_take_q || wrote_q) begin // RULE4
				dout_q <= mif.rdata;
			end
		end
	end

	// drivers follow read state; registered so outputs come from flops (one cycle lag)
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_data_oe <= 1'b0;
			o_data    <= '0;
		end else begin
			o_data_oe <= sel_q && i_write_n && drv_ok && (state_q == LSR_VALID) && i_cycle_strobe; // RULE13 RULE14 RULE6
			o_data    <= (rd_take_q || wrote_q) ? mif.rdata : dout_q;
		end
	end

	// status rises on valid data, falls when preset completes
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_memory_status <= 1'b0;
		end else if (state_q == LSR_VALID) begin // RULE7
			o_memory_status <= 1'b1;
		end else if (state_q == LSR_IDLE) begin
			o_memory_status <= 1'b0;
		end
	end

	lsr_array u_array (
		.i_clk (i_mclk),
		.mem   (mif.mem)
	);
endmodule : lsr_cycle_port

/* File: dv/lsr_chk.sv */
`timescale 1ns/1ps
module lsr_chk (
	input wire logic       i_mclk,
	input wire logic       i_nrst,
	input wire logic       i_cycle_strobe,
	input wire logic       i_chip_select,
	input wire logic       i_write_n,
	input wire logic       i_output_enable,
	input wire logic       i_drive_off_request,
	input wire logic [3:0] o_data,
	input wire logic       o_data_oe,
	input wire logic       o_memory_status
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_rise; !i_cycle_strobe[*8] ##1 i_cycle_strobe; endsequence
	sequence s_held; i_cycle_strobe[*6]; endsequence
	property p_valid; s_rise ##1 s_held |=> o_memory_status; endproperty
	a_valid: assert property (p_valid) else $error("status late");
	property p_unsel; (s_rise ##0 !i_chip_select) ##1 s_held |=> !o_data_oe; endproperty
	a_unsel: assert property (p_unsel) else $error("unselected drive");
	property p_rise; $rose(o_memory_status) |-> $past(i_cycle_strobe, 2) && $past(i_cycle_strobe, 5); endproperty
	a_rise: assert property (p_rise) else $error("status early");
	property p_fall; $fell(o_memory_status) |-> !$past(i_cycle_strobe) && !$past(i_cycle_strobe, 3); endproperty
	a_fall: assert property (p_fall) else $error("preset short");
	property p_gate; o_data_oe |-> $past(i_output_enable) && !$past(i_drive_off_request); endproperty
	a_gate: assert property (p_gate) else $error("drive ungated");
	property p_wr; !i_write_n |=> !o_data_oe; endproperty
	a_wr: assert property (p_wr) else $error("drive in write");
	property p_hold; o_data_oe && $past(o_data_oe) |-> $stable(o_data); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_stall; o_memory_status && i_cycle_strobe |=> o_memory_status; endproperty
	a_stall: assert property (p_stall) else $error("status lost");
endmodule : lsr_chk
bind lsr_cycle_port lsr_chk i_chk (.*);

/* File: dv/lsr_ctl.sv */
`timescale 1ns/1ps
module lsr_ctl (
	input  wire logic       i_mclk,
	input  wire logic       i_status,
	input  wire logic       i_oe,
	input  wire logic [3:0] i_pins,
	output logic            o_strobe,
	output logic            o_sel,
	output logic            o_write_n,
	output logic [9:0]      o_addr,
	output logic [3:0]      o_data
);
	logic [3:0] rd_q;
	logic       oe_q;
	int         n;
	initial {o_strobe, o_sel, o_write_n, o_addr, o_data} = 17'h04000;
	// released lines carry the inverse word so a stale copy cannot pass
	task automatic run(input logic s, w, input logic [9:0] a, input logic [3:0] d, input int st, input bit m,
		output bit to);
		n = 0;
		o_sel <= s;
		o_write_n <= w;
		o_addr <= a;
		o_data <= w ? ~d : d;
		o_strobe <= 1'b1;
		@(posedge i_mclk);
		o_addr <= ~a;
		do @(negedge i_mclk); while (!i_status && ++n < 20);
		rd_q = i_pins;
		oe_q = i_oe;
		// write data goes on only after status, so read data is taken first
		if (m) begin
			@(posedge i_mclk);
			o_write_n <= 1'b0;
			o_data <= d;
		end
		repeat (st + 1) @(posedge i_mclk);
		o_strobe <= 1'b0;
		o_write_n <= 1'b1;
		o_data <= ~d;
		do @(negedge i_mclk); while (i_status && ++n < 40);
		repeat (5) @(posedge i_mclk);
		to = n > 19;
	endtask : run
endmodule : lsr_ctl

/* File: dv/lsr_cycle_port_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s %h %h", n, e, g); end end
module lsr_cycle_port_tb;
	logic       i_mclk, i_nrst, strobe, sel, wn, en, off, d_oe, status;
	logic [9:0] addr;
	logic [3:0] cd, dout;
	wire  [3:0] pins = d_oe ? dout : cd;
	int         fail_count, num_checks;
	lsr_cycle_port i_dut (.i_mclk, .i_nrst, .i_cycle_strobe(strobe), .i_chip_select(sel), .i_write_n(wn),
		.i_addr(addr), .i_output_enable(en), .i_drive_off_request(off), .i_data(pins), .o_data(dout),
		.o_data_oe(d_oe), .o_memory_status(status));
	lsr_ctl i_ctl (.i_mclk, .i_status(status), .i_oe(d_oe), .i_pins(pins), .o_strobe(strobe), .o_sel(sel),
		.o_write_n(wn), .o_addr(addr), .o_data(cd));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic cyc(input logic s, w, input logic [9:0] a, input logic [3:0] d, input int st, input bit m = 0);
		bit to;
		i_ctl.run(s, w, a, d, st, m, to);
		if (to) begin
			fail_count++;
			complete_run();
		end
	endtask : cyc
	task automatic t_rw; // array ends written, then read with growing stalls
		for (int i = 0; i < 3; i++)
			cyc(1, 0, 10'(i * 'h3ff), 4'(i + 9), 0);
		for (int i = 0; i < 3; i++) begin
			cyc(1, 1, 10'(i * 'h3ff), 4'h0, i);
			`CHK("rd", 4'(i + 9), i_ctl.rd_q)
			`CHK("oe", 1'b1, i_ctl.oe_q)
		end
	endtask : t_rw
	task automatic t_sel;
		cyc(0, 0, 10'h3ff, 4'h5, 0);
		cyc(0, 1, 10'h3ff, 4'h0, 0);
		`CHK("oe", 1'b0, i_ctl.oe_q)
		cyc(1, 1, 10'h3ff, 4'h0, 0);
		`CHK("rd", 4'ha, i_ctl.rd_q)
	endtask : t_sel
	task automatic t_rmw;
		cyc(1, 1, 10'h3ff, 4'h6, 2, 1);
		`CHK("rmw_rd", 4'ha, i_ctl.rd_q)
		cyc(1, 1, 10'h3ff, 4'h0, 0);
		`CHK("rmw_wr", 4'h6, i_ctl.rd_q)
	endtask : t_rmw
	task automatic t_dis;
		off <= 1'b1;
		cyc(1, 1, 10'h000, 4'h0, 0);
		`CHK("oe", 1'b0, i_ctl.oe_q)
		off <= 1'b0;
		en <= 1'b0;
		cyc(1, 1, 10'h000, 4'h0, 0);
		`CHK("oe", 1'b0, i_ctl.oe_q)
		en <= 1'b1;
		cyc(1, 1, 10'h000, 4'h0, 0);
		`CHK("rd", 4'h9, i_ctl.rd_q)
	endtask : t_dis
	initial begin
		i_nrst = 1'b0;
		en = 1'b1;
		off = 1'b0;
		repeat (10) @(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (10) @(posedge i_mclk);
		t_rw();
		t_sel();
		t_rmw();
		t_dis();
		complete_run();
	end
endmodule : lsr_cycle_port_tb
